//--- rxgd_pkg.sv
// Package for the receive gain and demodulator control block.
// Holds field layouts, codes, thresholds, the gain table used by the top module and a correction table.
package rxgd_pkg;
  localparam int LEVEL_W = 7;
  localparam int BW_W = 10;
  localparam int SAMPLE_W = 8;
  localparam logic [1:0] OCD_DIV4 = 2'h0;
  localparam logic [1:0] OCD_DIV8 = 2'h1;
  localparam logic [1:0] OCD_DIV16 = 2'h2;
  localparam logic [4:0] OCD_HALF4 = 5'h02;
  localparam logic [4:0] OCD_HALF8 = 5'h04;
  localparam logic [4:0] OCD_HALF16 = 5'h08;
  localparam logic [1:0] DEMOD_LINEAR = 2'h0;
  localparam logic [1:0] DEMOD_CORR = 2'h1;
  localparam logic [1:0] DEMOD_ASK = 2'h2;
  localparam logic [6:0] THR_LOW_DEF = 7'h1E;
  localparam logic [6:0] THR_HIGH_DEF = 7'h46;
  localparam logic [7:0] DELAY_DEF = 8'h0A;
  localparam logic [2:0] GAIN_STEPS = 3'h5;
  localparam logic [2:0] GAIN_TOP = 3'h0;
  localparam int CDR_OVERSAMPLE = 32;
  localparam logic [4:0] CDR_HALF = 5'h10;
  localparam logic [4:0] CDR_NUDGE = 5'h01;
  // Clocks per oversample tick times bandwidth code, for a cutoff at 0.75 of the bit rate
  localparam logic [11:0] CDR_SCALE = 12'h097;
  localparam int FILT_SHIFT = 10;
  localparam int AVG_SHIFT = 6;

  typedef struct packed {
    logic [1:0] lna;
    logic [1:0] filt;
  } rxgd_gain_t;

  typedef struct packed {
    logic [LEVEL_W-1:0] level;
    rxgd_gain_t gain;
  } rxgd_readback_t;

  // Gain states from highest (0) to extra-low (5)
  function automatic rxgd_gain_t gain_of(input logic [2:0] st);
    case (st)
      3'h0: gain_of = '{lna: 2'h3, filt: 2'h2};
      3'h1: gain_of = '{lna: 2'h2, filt: 2'h2};
      3'h2: gain_of = '{lna: 2'h2, filt: 2'h1};
      3'h3: gain_of = '{lna: 2'h2, filt: 2'h0};
      3'h4: gain_of = '{lna: 2'h1, filt: 2'h0};
      default: gain_of = '{lna: 2'h0, filt: 2'h0};
    endcase
  endfunction

  // Correction in half-dB steps added to the level code
  function automatic logic [6:0] correction_of(input rxgd_gain_t g);
    case ({g.lna, g.filt})
      4'hE: correction_of = 7'h00;
      4'hA: correction_of = 7'h18;
      4'h9: correction_of = 7'h2D;
      4'h8: correction_of = 7'h3F;
      4'h4: correction_of = 7'h5A;
      4'h0: correction_of = 7'h69;
      default: correction_of = 7'h00;
    endcase
  endfunction
endpackage

//--- rxgd_top.sv
// Receive back end: offset clock divider, gain loop, level readback, three
// demodulators, post filter, slicer and 32x clock recovery.
// Assumes level code and quadrature limiter bits arrive asynchronously from the front end.
// Operation
// - Offset clock is crystal divided by 4, 8 or 16 from two-bit field.
// - Gain loop enabled at reset, picks gains from level, disable by write.
// - After each gain change wait delay times sequencer divider crystal periods.
// - Readback carries seven-bit level code; power from code plus correction.
// - Readback shows lna and filter gain bits mapping to fixed corrections.
// - Select 01 uses the correlator demodulator.
// - Select 00 uses the linear demodulator.
// - Select 10 uses ASK/OOK demodulation.
// - Correlator compares energy at IF plus and minus deviation.
// - Second-order low-pass after discriminator, ten-bit bandwidth.
// - Correlator slicer threshold is fixed zero.
// - Oversampled PLL at 32x data rate retimes data, tolerates 2 percent.
// - Linear mode slices filtered discriminator against its average.
// - ASK mode slices filtered level against its running average.
// - Reduce gain above high threshold, increase below low threshold.
// - Seven-bit level code feeds readback and gain control.
`timescale 1ns/1ns
module rxgd_top #(
  parameter int DIV_W = 8
) (
  input wire logic sys_clk, // 20 MHz
  input wire logic nrst, // Async reset, low
  input wire logic [1:0] offset_clock_divider, // 0:/4 1:/8 2:/16
  input wire logic gain_loop_enable, // Gain loop on
  input wire logic manual_gain_write, // Pulse: load manual gains while loop off
  input wire logic [1:0] manual_lna_gain, // Manual lna gain
  input wire logic [1:0] manual_filter_gain, // Manual filter gain
  input wire logic [7:0] gain_loop_delay, // Wait in sequencer ticks
  input wire logic [DIV_W-1:0] sequencer_clock_divider, // Crystal periods per tick
  input wire logic [6:0] gain_high_threshold, // Reduce gain above
  input wire logic [6:0] gain_low_threshold, // Raise gain below
  input wire logic extra_low_disable, // Skip extra-low step
  input wire logic [1:0] demod_select, // Demodulator mode
  input wire logic [9:0] post_filter_bandwidth, // Filter coefficient
  input wire logic receive_invert_bit, // Invert data
  input wire logic [6:0] level_in, // Flash converter code, async
  input wire logic if_i, // Limited I, async
  input wire logic if_q, // Limited Q, async
  output logic baseband_offset_clock, // Divided offset clock
  output rxgd_pkg::rxgd_readback_t readback, // Level and gain bits
  output logic [1:0] lna_gain, // Drive to front end
  output logic [1:0] filter_gain, // Drive to IF filter
  output logic rx_data, // Retimed data
  output logic rx_clk // Recovered clock
);
  logic [6:0] lvl_s1_reg, lvl_reg;
  logic [1:0] iq_s1_reg, iq_reg, iq_d_reg;
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
    begin
      lvl_s1_reg <= 7'h00;
      lvl_reg <= 7'h00;
      iq_s1_reg <= 2'h0;
      iq_reg <= 2'h0;
      iq_d_reg <= 2'h0;
    end
    else
    begin
      lvl_s1_reg <= level_in;
      lvl_reg <= lvl_s1_reg;
      iq_s1_reg <= {if_i, if_q};
      iq_reg <= iq_s1_reg;
      iq_d_reg <= iq_reg;
    end

  // Offset clock: toggle every half period
  logic [4:0] ocd_cnt_reg;
  logic ocd_clk_reg;
  wire [4:0] ocd_half = (offset_clock_divider == rxgd_pkg::OCD_DIV4) ? rxgd_pkg::OCD_HALF4 :
    (offset_clock_divider == rxgd_pkg::OCD_DIV8) ? rxgd_pkg::OCD_HALF8 :
    rxgd_pkg::OCD_HALF16;
  wire ocd_wrap = (ocd_cnt_reg + 5'h01) >= ocd_half;
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
    begin
      ocd_cnt_reg <= 5'h00;
      ocd_clk_reg <= 1'b0;
    end
    else if (ocd_wrap)
    begin
      ocd_cnt_reg <= 5'h00;
      ocd_clk_reg <= ~ocd_clk_reg;
    end
    else
      ocd_cnt_reg <= ocd_cnt_reg + 5'h01;

  // Gain loop
  typedef enum logic [1:0] {ST_WATCH, ST_SETTLE, ST_HOLD} rxgd_gst_t;
  rxgd_gst_t gst_reg;
  logic [2:0] step_reg;
  logic [7:0] dly_reg;
  logic [DIV_W-1:0] pre_reg;
  rxgd_pkg::rxgd_gain_t gain_reg;
  wire tick = (pre_reg + {{(DIV_W-1){1'b0}}, 1'b1}) >= sequencer_clock_divider;
  wire [2:0] bottom = extra_low_disable ? (rxgd_pkg::GAIN_STEPS - 3'h1) : rxgd_pkg::GAIN_STEPS;
  wire go_down = (lvl_reg > gain_high_threshold) && (step_reg < bottom);
  wire go_up = (lvl_reg < gain_low_threshold) && (step_reg > rxgd_pkg::GAIN_TOP);
  wire [2:0] step_next = go_down ? step_reg + 3'h1 : step_reg - 3'h1;
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
    begin
      gst_reg <= ST_WATCH;
      step_reg <= rxgd_pkg::GAIN_TOP;
      dly_reg <= 8'h00;
      pre_reg <= '0;
      gain_reg <= rxgd_pkg::gain_of(rxgd_pkg::GAIN_TOP);
    end
    else
    begin
      pre_reg <= tick ? '0 : pre_reg + {{(DIV_W-1){1'b0}}, 1'b1};
      case (gst_reg)
        ST_WATCH:
          if (!gain_loop_enable)
            gst_reg <= ST_HOLD;
          else if (go_down || go_up)
          begin
            step_reg <= step_next;
            gain_reg <= rxgd_pkg::gain_of(step_next);
            dly_reg <= gain_loop_delay;
            pre_reg <= '0;
            gst_reg <= ST_SETTLE;
          end
        ST_SETTLE:
          if (!gain_loop_enable)
            gst_reg <= ST_HOLD;
          else if (dly_reg == 8'h00)
            gst_reg <= ST_WATCH;
          else if (tick)
            dly_reg <= dly_reg - 8'h01;
        ST_HOLD:
        begin
          if (manual_gain_write)
            gain_reg <= '{lna: manual_lna_gain, filt: manual_filter_gain};
          if (gain_loop_enable)
            gst_reg <= ST_WATCH;
        end
        default: gst_reg <= ST_WATCH;
      endcase
    end

  // Correlator: quadrature phase-step direction, + for IF+dev, - for IF-dev
  wire fwd = (iq_reg == {iq_d_reg[0], ~iq_d_reg[1]});
  wire bwd = (iq_reg == {~iq_d_reg[0], iq_d_reg[1]});
  logic signed [15:0] corr_hi_reg, corr_lo_reg, disc_lin_reg;
  wire signed [15:0] corr_diff = corr_hi_reg - corr_lo_reg;
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
    begin
      corr_hi_reg <= 16'sh0000;
      corr_lo_reg <= 16'sh0000;
      disc_lin_reg <= 16'sh0000;
    end
    else
    begin
      corr_hi_reg <= corr_hi_reg - (corr_hi_reg >>> 4) + (fwd ? 16'sh0100 : 16'sh0000);
      corr_lo_reg <= corr_lo_reg - (corr_lo_reg >>> 4) + (bwd ? 16'sh0100 : 16'sh0000);
      disc_lin_reg <= disc_lin_reg - (disc_lin_reg >>> 4) +
        (fwd ? 16'sh0100 : (bwd ? -16'sh0100 : 16'sh0000));
    end

  // Mode mux; 11 falls through to linear
  wire signed [15:0] disc_in = (demod_select == rxgd_pkg::DEMOD_CORR) ? corr_diff :
    (demod_select == rxgd_pkg::DEMOD_ASK) ? $signed({2'h0, lvl_reg, 7'h00}) :
    disc_lin_reg;
  wire use_zero = (demod_select == rxgd_pkg::DEMOD_CORR);

  // Second-order low-pass: two cascaded one-pole stages sharing the coefficient
  logic signed [31:0] lp1_reg, lp2_reg, avg_reg;
  wire signed [31:0] in_w = {{6{disc_in[15]}}, disc_in, 10'h000};
  wire signed [42:0] d1 = (in_w - lp1_reg) * $signed({1'b0, post_filter_bandwidth});
  wire signed [42:0] d2 = (lp1_reg - lp2_reg) * $signed({1'b0, post_filter_bandwidth});
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
    begin
      lp1_reg <= 32'sh0;
      lp2_reg <= 32'sh0;
      avg_reg <= 32'sh0;
    end
    else
    begin
      lp1_reg <= lp1_reg + 32'(d1 >>> rxgd_pkg::FILT_SHIFT);
      lp2_reg <= lp2_reg + 32'(d2 >>> rxgd_pkg::FILT_SHIFT);
      avg_reg <= avg_reg + ((lp2_reg - avg_reg) >>> rxgd_pkg::AVG_SHIFT);
    end
  wire sliced = (use_zero ? (lp2_reg > 32'sh0) : (lp2_reg > avg_reg)) ^ receive_invert_bit;

  // Clock recovery: 32 phases per bit, nudged toward each data edge
  logic [4:0] ph_reg;
  logic sl_d_reg, data_reg, rclk_reg;
  logic [11:0] ovs_reg;
  logic [11:0] bit_period_reg;
  wire [4:0] ph_step = (sl_d_reg != sliced) ? ((ph_reg < rxgd_pkg::CDR_HALF) ?
    rxgd_pkg::CDR_NUDGE + rxgd_pkg::CDR_NUDGE : 5'h00) : rxgd_pkg::CDR_NUDGE;
  wire ovs_tick = (ovs_reg + 12'h001) >= bit_period_reg;
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
    begin
      ph_reg <= 5'h00;
      sl_d_reg <= 1'b0;
      data_reg <= 1'b0;
      rclk_reg <= 1'b0;
      ovs_reg <= 12'h000;
      bit_period_reg <= 12'h001;
    end
    else
    begin
      // Tick rate is inferred from the filter cutoff, so 32 ticks span one bit only
      // while the cutoff is kept near 0.75 of the bit rate; rounded to nearest
      bit_period_reg <= (post_filter_bandwidth == 10'h000) ? 12'h001 :
        12'((rxgd_pkg::CDR_SCALE + {3'h0, post_filter_bandwidth[9:1]}) /
        {2'h0, post_filter_bandwidth});
      ovs_reg <= ovs_tick ? 12'h000 : ovs_reg + 12'h001;
      if (ovs_tick)
      begin
        sl_d_reg <= sliced;
        ph_reg <= ph_reg + ph_step;
        rclk_reg <= (ph_reg >= rxgd_pkg::CDR_HALF);
        if (ph_reg == rxgd_pkg::CDR_HALF)
          data_reg <= sliced;
      end
    end

  // Outputs straight from flip-flops
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
    begin
      readback <= '0;
      baseband_offset_clock <= 1'b0;
      lna_gain <= 2'h0;
      filter_gain <= 2'h0;
      rx_data <= 1'b0;
      rx_clk <= 1'b0;
    end
    else
    begin
      readback <= '{level: lvl_reg, gain: gain_reg};
      baseband_offset_clock <= ocd_clk_reg;
      lna_gain <= gain_reg.lna;
      filter_gain <= gain_reg.filt;
      rx_data <= data_reg;
      rx_clk <= rclk_reg;
    end
endmodule // rxgd_top

//--- rxgd_top_sva.sv
// Checker for the receive gain and demodulator top module.
// Assumes 70/30 thresholds, a 500-cycle gain wait and level 0 during reset.
`timescale 1ns/1ns
module rxgd_top_sva (
  input wire logic sys_clk, // Clock
  input wire logic nrst, // Reset, low
  input wire logic [1:0] offset_clock_divider, // Divider select
  input wire logic gain_loop_enable, // Loop on
  input wire logic manual_gain_write, // Manual load
  input wire logic [6:0] gain_high_threshold, // Upper
  input wire logic [6:0] gain_low_threshold, // Lower
  input wire logic extra_low_disable, // Bottom is state 4
  input wire logic [6:0] level_in, // Level code
  input wire logic baseband_offset_clock, // Offset clock
  input wire rxgd_pkg::rxgd_readback_t readback, // Readback
  input wire logic [1:0] lna_gain, // Lna gain
  input wire logic [1:0] filter_gain // Filter gain
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic seen;
  wire bb = baseband_offset_clock;
  wire [3:0] g = {lna_gain, filter_gain};
  wire bottom = (g == 4'h0) || (extra_low_disable && g == 4'h4);
  wire calm = !gain_loop_enable && !manual_gain_write;
  wire hi = level_in > gain_high_threshold;
  wire lo = level_in < gain_low_threshold;
  // Outputs only settle one edge after release
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
      seen <= 1'b0;
    else
      seen <= 1'b1;
  sequence s_half4; bb ##1 !bb; endsequence
  sequence s_half16; bb [*7] ##1 !bb; endsequence
  property p_div4; $rose(bb) && offset_clock_divider == rxgd_pkg::OCD_DIV4 |=> s_half4; endproperty
  property p_div16; $rose(bb) && offset_clock_divider == rxgd_pkg::OCD_DIV16 |=> s_half16;
  endproperty
  property p_pair; seen |-> readback.gain.lna == lna_gain && readback.gain.filt == filter_gain;
  endproperty
  property p_legal; g inside {4'hE, 4'hA, 4'h9, 4'h8, 4'h4, 4'h0}; endproperty
  property p_wait; seen && gain_loop_enable && $changed(g) |=> $stable(g) [*8]; endproperty
  property p_hold; calm [*3] |=> $stable(g); endproperty
  property p_level; seen |-> readback.level == $past(level_in, 3); endproperty
  property p_down; (hi && gain_loop_enable && !bottom) [*8] |-> ##[0:520] $changed(g); endproperty
  property p_up; (lo && gain_loop_enable && g != 4'hE) [*8] |-> ##[0:520] $changed(g); endproperty
  a_div4: assert property (p_div4) else $error("offset clock high phase at /4");
  a_div16: assert property (p_div16) else $error("offset clock high phase at /16");
  a_pair: assert property (p_pair) else $error("readback gain differs from outputs");
  a_legal: assert property (p_legal) else $error("gain pair outside table");
  a_wait: assert property (p_wait) else $error("gain changed inside wait");
  a_hold: assert property (p_hold) else $error("gain moved while loop off");
  a_level: assert property (p_level) else $error("level code latency");
  a_down: assert property (p_down) else $error("gain not reduced");
  a_up: assert property (p_up) else $error("gain not raised");
endmodule // rxgd_top_sva

bind rxgd_top rxgd_top_sva rxgd_top_sva_i (.sys_clk, .nrst, .offset_clock_divider,
  .gain_loop_enable, .manual_gain_write, .gain_high_threshold, .gain_low_threshold,
  .extra_low_disable, .level_in, .baseband_offset_clock, .readback, .lna_gain, .filter_gain);

//--- rxgd_front.sv
// Stand-in for the limited quadrature IF of the analogue chain.
// Assumes a tone step every two clocks, well inside the sample rate.
`timescale 1ns/1ns
module rxgd_front (
  input wire logic sys_clk, // Clock
  input wire logic tone_bit, // 1: upper tone
  output logic if_i, // Limited I
  output logic if_q // Limited Q
);
  logic [2:0] ph = 3'h0;
  // Rotation sense carries the tone, so both correlators see a clear winner
  always @(negedge sys_clk)
    // Tones sit symmetric about the IF with no offset, so no frequency correction is due
    ph <= tone_bit ? ph + 3'h1 : ph - 3'h1;
  assign if_i = ph[2];
  assign if_q = ph[2] ^ ph[1];
endmodule // rxgd_front

//--- rxgd_top_bench.sv
// Bench for the receive gain and demodulator block.
// Assumes the front-end stand-in and one reset at start.
`timescale 1ns/1ns
module rxgd_top_bench;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] div_sel = 2'h0;
  logic loop_en = 1'b1;
  logic man_wr = 1'b0;
  logic [1:0] man_lna = 2'h0;
  logic [1:0] man_filt = 2'h0;
  logic xlow = 1'b0;
  logic inv = 1'b0;
  logic [1:0] demod = 2'h0;
  logic [6:0] level = 7'h00;
  logic tone = 1'b0;
  logic if_i, if_q, bb_clk, rx_data, rx_clk, prev, saw0, saw1;
  rxgd_pkg::rxgd_readback_t rb;
  logic [1:0] lna, filt;
  logic [3:0] steps [6] = '{4'hE, 4'hA, 4'h9, 4'h8, 4'h4, 4'h0};
  int num_errors = 0;
  int total_checks = 0;
  int i, s, n, k, r;
  // Per-step gain wait of 25 us at the 50 ns clock
  localparam int SEQ_DIV = 50;
  localparam int WAIT_CYC = int'(rxgd_pkg::DELAY_DEF) * SEQ_DIV;
  always #25 sys_clk = ~sys_clk;
  rxgd_front rxgd_front_i (.sys_clk, .tone_bit(tone), .if_i, .if_q);
  rxgd_top #(.DIV_W(8)) rxgd_top_i (.sys_clk, .nrst, .offset_clock_divider(div_sel),
    .gain_loop_enable(loop_en), .manual_gain_write(man_wr), .manual_lna_gain(man_lna),
    .manual_filter_gain(man_filt), .gain_loop_delay(rxgd_pkg::DELAY_DEF),
    .sequencer_clock_divider(8'(SEQ_DIV)),
    .gain_high_threshold(rxgd_pkg::THR_HIGH_DEF), .gain_low_threshold(rxgd_pkg::THR_LOW_DEF),
    .extra_low_disable(xlow), .demod_select(demod), .post_filter_bandwidth(10'h026),
    .receive_invert_bit(inv), .level_in(level), .if_i, .if_q, .baseband_offset_clock(bb_clk),
    .readback(rb), .lna_gain(lna), .filter_gain(filt), .rx_data, .rx_clk);
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge sys_clk);
  endtask
  // Bounded so a stuck gain loop ends the run instead of hanging it
  task automatic wait_gain(input logic [3:0] exp, output int w);
    for (w = 0; w < 1000 && {lna, filt} !== exp; w++)
      cyc(1);
    chk("gain pair", {4'h0, exp}, {4'h0, lna, filt});
    if (w == 1000)
      conclude();
  endtask
  initial
  begin
    cyc(16);
    nrst = 1'b1;
    cyc(2);
    chk("reset gain", 8'h0E, {4'h0, lna, filt});
    for (i = 0; i < 3; i++)
    begin
      div_sel = 2'(i);
      cyc(40);
      n = 0;
      repeat (256)
      begin
        prev = bb_clk;
        cyc(1);
        n += int'(bb_clk && !prev);
      end
      chk("offset clock rises", 8'h40 >> i, 8'(n));
    end
    // Only the /16 setting keeps a 20 MHz crystal inside the 1 to 2 MHz band
    div_sel = rxgd_pkg::OCD_DIV16;
    level = 7'h28;
    cyc(8);
    chk("level code", 8'h28, {1'b0, rb.level});
    chk("gain in band", 8'h0E, {4'h0, lna, filt});
    xlow = 1'b1;
    level = 7'h64;
    for (s = 1; s < 5; s++)
    begin
      wait_gain(steps[s], k);
      if (s > 1)
        chk("gain wait", 8'h01, 8'(k >= WAIT_CYC && k <= WAIT_CYC + 8));
    end
    cyc(600);
    chk("extra-low skipped", 8'h04, {4'h0, lna, filt});
    xlow = 1'b0;
    wait_gain(steps[5], k);
    level = 7'h0A;
    for (s = 4; s >= 0; s--)
      wait_gain(steps[s], k);
    loop_en = 1'b0;
    cyc(3);
    level = 7'h64;
    cyc(600);
    chk("held gain", 8'h0E, {4'h0, lna, filt});
    man_lna = 2'h2;
    man_filt = 2'h1;
    man_wr = 1'b1;
    cyc(1);
    man_wr = 1'b0;
    cyc(4);
    chk("manual gain", 8'h09, {4'h0, lna, filt});
    level = 7'h24;
    loop_en = 1'b1;
    for (i = 0; i < 4; i++)
    begin
      demod = 2'(i);
      // Correlator tuned for K of 10: K/2 is odd, so data inversion is set
      inv = (i == 1);
      saw0 = 1'b0;
      saw1 = 1'b0;
      r = 0;
      for (s = 0; s < 32; s++)
      begin
        tone = s[1];
        level = (i == 2 && s[1]) ? 7'h40 : 7'h24;
        repeat (128)
        begin
          prev = rx_clk;
          cyc(1);
          r += int'(rx_clk && !prev);
          saw0 |= (rx_data === 1'b0);
          saw1 |= (rx_data === 1'b1);
        end
      end
      chk("data low seen", 8'h01, {7'h0, saw0});
      chk("data high seen", 8'h01, {7'h0, saw1});
      chk("recovered clock", 8'h01, 8'(r >= 28 && r <= 36));
    end
    conclude();
  end
endmodule // rxgd_top_bench
